// *** src/eccp_ctrl.sv ***
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module eccp_ctrl #(
	parameter int ADDR_W  = 8,
	parameter int UNIT_CH = 0
) (
	input  logic              aclk,
	input  logic              aresetn,
	input  logic [ADDR_W-1:0] awaddr,
	input  logic              awvalid,
	output logic              awready,
	input  logic [31:0]       wdata,
	input  logic [3:0]        wstrb,
	input  logic              wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  logic              bready,
	input  logic [ADDR_W-1:0] araddr,
	input  logic              arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  logic              rready,
	input  logic [2:0]        tmr_period_match,
	input  logic              pwm_raw,
	input  logic [3:0]        unit_mode_field,
	input  logic [1:0]        output_config_field,
	input  logic [1:0]        comparator_out,
	input  logic [1:0]        comparator_sync_option,
	input  logic              timer1_sync_tick,
	input  logic              fault_input_pin,
	output logic [3:0]        chan_period_match,
	output logic              pwm_out_a,
	output logic              pwm_out_a_oe,
	output logic              pwm_out_b,
	output logic              pwm_out_b_oe,
	output logic              pwm_out_c,
	output logic              pwm_out_c_oe,
	output logic              pwm_out_d,
	output logic              pwm_out_d_oe,
	output logic [3:0]        steer_owned,
	output logic              shutdown_status,
	output logic              irq
);
	localparam logic [ADDR_W-1:0] A_TB =
		ADDR_W'(eccp_pkg::TIMEBASE_OFFS);
	localparam logic [ADDR_W-1:0] A_SD =
		ADDR_W'(eccp_pkg::SHUTDOWN_OFFS);
	localparam logic [ADDR_W-1:0] A_RS =
		ADDR_W'(eccp_pkg::RESTART_OFFS);
	localparam logic [ADDR_W-1:0] A_ST =
		ADDR_W'(eccp_pkg::STEER_OFFS);
	localparam logic [ADDR_W-1:0] A_IS =
		ADDR_W'(eccp_pkg::IRQ_STATUS_OFFS);
	localparam logic [ADDR_W-1:0] A_IM =
		ADDR_W'(eccp_pkg::IRQ_MASK_OFFS);
	localparam logic [1:0] DIV_LAST =
		2'(eccp_pkg::INSTR_CLKS - 1);

	typedef struct packed {
		logic [7:0]        tsel;
		logic              sd_status;
		logic [2:0]        sd_src;
		logic [1:0]        sd_ac;
		logic [1:0]        sd_bd;
		logic              restart_en;
		logic [6:0]        delay;
		logic              steer_sync;
		logic [3:0]        steer_req;
		logic [3:0]        steer_act;
		logic [1:0]        irq_status;
		logic [1:0]        irq_mask;
		logic              aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_got;
		logic [7:0]        w_byte;
		logic              w_lane;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [7:0]        rdata;
		logic [1:0]        rresp;
		logic [1:0]        div;
		logic              pwm_run;
		logic [1:0]        cmp_held;
		logic [3:0]        chan_match;
		logic [3:0]        pin_val;
		logic [3:0]        pin_oe;
		logic [3:0]        pin_own;
	} state_t;

	state_t     s;
	state_t     next_s;
	logic [1:0] cmp_s;
	logic       fault_s;
	logic [1:0] cmp_eff;
	logic       src_active;
	logic       steer_mode;
	logic       instr_tick;
	logic       wr_go;
	logic       sw_wr_sd;
	logic       delayed;
	logic [3:0] tb_match;
	logic       own_match;

	sync2 #(
		.W (3)
	) u_pin_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({fault_input_pin, comparator_out}),
		.q       ({fault_s, cmp_s})
	);

	dead_delay #(
		.CNT_W      (7),
		.INSTR_CLKS (eccp_pkg::INSTR_CLKS)
	) u_dead_delay (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.delay_count (s.delay),
		.raw         (pwm_raw),
		.delayed     (delayed)
	);

	// per-channel timebase routing
	for (genvar i = 0; i < 4; i++) begin : g_tb
		logic [1:0] sel;
		assign sel = s.tsel[2*i+1:2*i];
		always_comb begin
			unique case (sel)
				eccp_pkg::TSEL_FIRST:  tb_match[i] = tmr_period_match[0];
				eccp_pkg::TSEL_SECOND: tb_match[i] = tmr_period_match[1];
				eccp_pkg::TSEL_THIRD:  tb_match[i] = tmr_period_match[2];
				default:               tb_match[i] = 1'b0;
			endcase
		end
	end

	assign own_match = tb_match[UNIT_CH];
	// held comparator levels for synced sources
	assign cmp_eff = (comparator_sync_option & s.cmp_held) |
		(~comparator_sync_option & cmp_s);
	assign src_active = (s.sd_src[2] & ~fault_s) |
		(s.sd_src[0] & cmp_eff[0]) |
		(s.sd_src[1] & cmp_eff[1]);
	assign steer_mode = (unit_mode_field[3:2] == eccp_pkg::MODE_PWM) &&
		(output_config_field == eccp_pkg::CFG_SINGLE);
	assign instr_tick = (s.div == 2'h0);
	assign wr_go = s.aw_got && s.w_got && !s.bvalid;
	assign sw_wr_sd = wr_go && s.w_lane && (s.aw_addr == A_SD);

	always_comb begin
		logic [1:0] fld;
		logic       pol;
		logic [1:0] ev;
		fld = 2'h0;
		pol = 1'b0;
		ev = 2'h0;
		next_s = s;

		// bus write capture
		if (awvalid && awready) begin
			next_s.aw_got = 1'b1;
			next_s.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_s.w_got = 1'b1;
			next_s.w_byte = wdata[7:0];
			next_s.w_lane = wstrb[0];
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end

		// auto restart
		if (s.sd_status && s.restart_en && !src_active) begin
			next_s.sd_status = 1'b0;
		end

		// register write
		if (wr_go) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = eccp_pkg::RESP_OKAY;
			unique case (s.aw_addr)
				A_TB: begin
					if (s.w_lane) next_s.tsel = s.w_byte;
				end
				A_SD: begin
					if (s.w_lane) begin
						next_s.sd_status =
							s.w_byte[eccp_pkg::SD_STATUS_BIT];
						next_s.sd_src =
							s.w_byte[eccp_pkg::SD_SRC_LSB+:3];
						next_s.sd_ac = s.w_byte[eccp_pkg::SD_AC_LSB+:2];
						next_s.sd_bd = s.w_byte[eccp_pkg::SD_BD_LSB+:2];
					end
				end
				A_RS: begin
					if (s.w_lane) begin
						next_s.restart_en =
							s.w_byte[eccp_pkg::RESTART_EN_BIT];
						next_s.delay = s.w_byte[6:0];
					end
				end
				A_ST: begin
					if (s.w_lane) begin
						next_s.steer_sync =
							s.w_byte[eccp_pkg::STEER_SYNC_BIT];
						next_s.steer_req = s.w_byte[3:0];
					end
				end
				A_IS: begin
					if (s.w_lane) begin
						next_s.irq_status = s.irq_status & ~s.w_byte[1:0];
					end
				end
				A_IM: begin
					if (s.w_lane) next_s.irq_mask = s.w_byte[1:0];
				end
				default: next_s.bresp = eccp_pkg::RESP_SLVERR;
			endcase
		end

		// source sets status, winning over any clear
		if (src_active) begin
			next_s.sd_status = 1'b1;
		end

		// resume waits for the period boundary
		if (s.sd_status) begin
			next_s.pwm_run = 1'b0;
		end else if (!s.pwm_run && own_match) begin
			next_s.pwm_run = 1'b1;
		end

		// sticky events, set wins over clear
		ev[eccp_pkg::IRQ_SHUTDOWN] = src_active && !s.sd_status;
		ev[eccp_pkg::IRQ_RESUME] = !s.pwm_run && !s.sd_status &&
			own_match;
		next_s.irq_status = next_s.irq_status | ev;

		// bus read
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = eccp_pkg::RESP_OKAY;
			unique case (araddr)
				A_TB: next_s.rdata = s.tsel;
				A_SD: next_s.rdata = {s.sd_status, s.sd_src,
					s.sd_ac, s.sd_bd};
				A_RS: next_s.rdata = {s.restart_en, s.delay};
				A_ST: next_s.rdata = {3'h0, s.steer_sync,
					s.steer_req};
				A_IS: next_s.rdata = {6'h00, s.irq_status};
				A_IM: next_s.rdata = {6'h00, s.irq_mask};
				default: begin
					next_s.rdata = 8'h00;
					next_s.rresp = eccp_pkg::RESP_SLVERR;
				end
			endcase
		end

		// instruction cycle divider and comparator sync
		next_s.div = (s.div == DIV_LAST) ? 2'h0 : s.div + 2'h1;
		if (timer1_sync_tick) begin
			next_s.cmp_held = cmp_s;
		end

		// steering update point
		if (s.steer_sync ? own_match : instr_tick) begin
			next_s.steer_act = s.steer_req;
		end

		next_s.chan_match = tb_match;

		// output pins
		for (int i = 0; i < 4; i++) begin
			pol = (i % 2 == 0) ? unit_mode_field[1] :
				unit_mode_field[0];
			fld = (i % 2 == 0) ? s.sd_ac : s.sd_bd;
			next_s.pin_own[i] = steer_mode && s.steer_act[i];
			if (!next_s.pin_own[i]) begin
				next_s.pin_oe[i] = 1'b0;
				next_s.pin_val[i] = 1'b0;
			end else if (s.sd_status || !s.pwm_run) begin
				next_s.pin_oe[i] = !fld[1];
				next_s.pin_val[i] = !fld[1] && fld[0];
			end else begin
				next_s.pin_oe[i] = 1'b1;
				next_s.pin_val[i] = delayed ^ pol;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.tsel <= eccp_pkg::TIMEBASE_RST;
			s.sd_status <= eccp_pkg::SHUTDOWN_RST[7];
			s.sd_src <= eccp_pkg::SHUTDOWN_RST[6:4];
			s.sd_ac <= eccp_pkg::SHUTDOWN_RST[3:2];
			s.sd_bd <= eccp_pkg::SHUTDOWN_RST[1:0];
			s.restart_en <= eccp_pkg::RESTART_RST[7];
			s.delay <= eccp_pkg::RESTART_RST[6:0];
			s.steer_sync <= eccp_pkg::STEER_RST[4];
			s.steer_req <= eccp_pkg::STEER_RST[3:0];
			s.steer_act <= eccp_pkg::STEER_RST[3:0];
			s.irq_mask <= eccp_pkg::IRQ_MASK_RST;
			s.pwm_run <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign awready = !s.aw_got && !s.bvalid;
	assign wready = !s.w_got && !s.bvalid;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = !s.rvalid;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = {24'h000000, s.rdata};
	assign chan_period_match = s.chan_match;
	assign pwm_out_a = s.pin_val[0];
	assign pwm_out_a_oe = s.pin_oe[0];
	assign pwm_out_b = s.pin_val[1];
	assign pwm_out_b_oe = s.pin_oe[1];
	assign pwm_out_c = s.pin_val[2];
	assign pwm_out_c_oe = s.pin_oe[2];
	assign pwm_out_d = s.pin_val[3];
	assign pwm_out_d_oe = s.pin_oe[3];
	assign steer_owned = s.pin_own;
	assign shutdown_status = s.sd_status;
	assign irq = |(s.irq_status & s.irq_mask);

	a_tb_second: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s.tsel[1:0] == 2'h1) |-> ##1
		(chan_period_match[0] == $past(tmr_period_match[1])))
		else $error("channel one not on second timer");

	a_tb_reserved: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s.tsel[7:6] == 2'h3) |=> !chan_period_match[3])
		else $error("reserved timebase code produced a match");

	a_src_comp: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s.sd_src == 3'h2 && cmp_eff[1]) |=> shutdown_status)
		else $error("comparator two did not shut down");

	a_src_fault: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s.sd_src[2] && !fault_s) |=> shutdown_status)
		else $error("fault low did not shut down");

	a_sd_float_ac: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s.sd_status && s.sd_ac[1]) |=> !pwm_out_a_oe && !pwm_out_c_oe)
		else $error("A or C driven in float shutdown");

	a_sd_high_bd: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s.sd_status && s.sd_bd == 2'h1 && steer_mode && s.steer_act[1])
		|=> pwm_out_b_oe && pwm_out_b)
		else $error("B not driven high in shutdown");

	a_auto_clear: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s.sd_status && s.restart_en && !src_active && !sw_wr_sd)
		|=> !shutdown_status)
		else $error("auto restart did not clear status");

	a_manual_hold: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s.sd_status && !s.restart_en && !sw_wr_sd) |=> shutdown_status)
		else $error("status cleared without software");

	a_resume_period: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$rose(s.pwm_run) |-> $past(own_match) && !$past(s.sd_status))
		else $error("pwm resumed off the period boundary");

	a_steer_hold: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s.steer_sync && !own_match) |=> $stable(s.steer_act))
		else $error("steering changed between periods");
endmodule

// *** common/eccp_pkg.sv ***
package eccp_pkg;
	// register byte offsets
	localparam logic [7:0] TIMEBASE_OFFS   = 8'h00;
	localparam logic [7:0] SHUTDOWN_OFFS   = 8'h04;
	localparam logic [7:0] RESTART_OFFS    = 8'h08;
	localparam logic [7:0] STEER_OFFS      = 8'h0C;
	localparam logic [7:0] IRQ_STATUS_OFFS = 8'h10;
	localparam logic [7:0] IRQ_MASK_OFFS   = 8'h14;

	// reset values
	localparam logic [7:0] TIMEBASE_RST    = 8'h00;
	localparam logic [7:0] SHUTDOWN_RST    = 8'h00;
	localparam logic [7:0] RESTART_RST     = 8'h00;
	localparam logic [4:0] STEER_RST       = 5'h01;
	localparam logic [1:0] IRQ_MASK_RST    = 2'h0;

	// field positions
	localparam int SD_STATUS_BIT  = 7;
	localparam int SD_SRC_LSB     = 4;
	localparam int SD_AC_LSB      = 2;
	localparam int SD_BD_LSB      = 0;
	localparam int RESTART_EN_BIT = 7;
	localparam int STEER_SYNC_BIT = 4;
	localparam int IRQ_SHUTDOWN   = 0;
	localparam int IRQ_RESUME     = 1;

	// timebase select codes
	localparam logic [1:0] TSEL_FIRST    = 2'h0;
	localparam logic [1:0] TSEL_SECOND   = 2'h1;
	localparam logic [1:0] TSEL_THIRD    = 2'h2;

	// mode and output configuration
	localparam logic [1:0] MODE_PWM      = 2'h3;
	localparam logic [1:0] CFG_SINGLE    = 2'h0;

	// instruction cycle timing
	localparam int CLK_NS      = 5;
	localparam int TOSC_NS     = 5;
	localparam int INSTR_TOSC  = 4;
	localparam int INSTR_CLKS  = INSTR_TOSC * TOSC_NS / CLK_NS;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** src/sync2.sv ***
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	input  logic         aclk,
	input  logic         aresetn,
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;

	sync_t s;
	sync_t next_s;

	always_comb begin
		next_s.s1 = d;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.s2;
endmodule

// *** src/dead_delay.sv ***
`timescale 1ns/1ps
module dead_delay #(
	parameter int CNT_W      = 7,
	parameter int INSTR_CLKS = 4
) (
	input  logic             aclk,
	input  logic             aresetn,
	input  logic [CNT_W-1:0] delay_count,
	input  logic             raw,
	output logic             delayed
);
	localparam int TW = CNT_W + $clog2(INSTR_CLKS);

	typedef struct packed {
		logic [TW-1:0] cnt;
		logic          prev;
		logic          out;
	} delay_t;

	delay_t s;
	delay_t next_s;

	always_comb begin
		next_s = s;
		next_s.prev = raw;
		if (!raw) begin
			next_s.out = 1'b0;
			next_s.cnt = '0;
		end else if (!s.prev) begin
			if (delay_count == '0) begin
				next_s.out = 1'b1;
			end else begin
				next_s.cnt = TW'(delay_count * INSTR_CLKS);
			end
		end else if (s.cnt > TW'(1)) begin
			next_s.cnt = s.cnt - TW'(1);
		end else begin
			next_s.cnt = '0;
			next_s.out = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign delayed = s.out;

	a_delay_hold: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(raw && !s.prev && delay_count != '0) |=> !delayed)
		else $error("active edge not postponed");

	a_delay_one: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(raw && !s.prev && delay_count == CNT_W'(1)) ##1 raw[*4]
		|=> delayed)
		else $error("one-cycle delay wrong length");

	a_delay_fall: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!raw |=> !delayed)
		else $error("inactive edge was delayed");
endmodule

// *** tb/switch_model.sv ***
`timescale 1ns/1ps
module switch_model (
	input  wire logic       aclk,
	input  wire logic [1:0] cmp_high,
	input  wire logic       fault_low,
	input  wire logic [3:0] pin_out,
	input  wire logic [3:0] pin_oe,
	output logic      [1:0] comparator_out,
	output logic            fault_input_pin,
	output logic      [3:0] pin_level
);
	initial comparator_out = 2'h0;
	initial fault_input_pin = 1'b1;
	// comparator and fault levels move just after a clock edge
	always @(posedge aclk) begin
		comparator_out <= cmp_high;
		fault_input_pin <= !fault_low;
	end
	// released pins are pulled down so the switches stay off
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_level[i] = pin_oe[i] ? pin_out[i] : 1'b0;
		end
	end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, pwm_raw = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0, unit_mode_field = 4'hC;
	logic [1:0] output_config_field = 2'h0, cmp_high = 2'h0;
	logic [1:0] comparator_sync_option = 2'h0;
	logic [2:0] tmr_period_match = 3'h0;
	logic timer1_sync_tick = 1'b0, fault_low = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, fault_input_pin;
	logic [1:0] bresp, rresp, comparator_out;
	logic [31:0] rdata;
	logic [3:0] chan_period_match, steer_owned, pin_level, pout, poe;
	logic shutdown_status, irq;
	logic [7:0] pins;
	int err_count = 0, checks = 0, cyc = 0;
	logic [1:0] r;
	logic [1:0] bres = 2'h0;
	logic [7:0] d;
	assign pins = {poe, pin_level};
	always #2.5 aclk = ~aclk;
	eccp_ctrl eccp_ctrl_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .tmr_period_match(tmr_period_match),
		.pwm_raw(pwm_raw), .unit_mode_field(unit_mode_field),
		.output_config_field(output_config_field),
		.comparator_out(comparator_out),
		.comparator_sync_option(comparator_sync_option),
		.timer1_sync_tick(timer1_sync_tick),
		.fault_input_pin(fault_input_pin),
		.chan_period_match(chan_period_match), .pwm_out_a(pout[0]),
		.pwm_out_a_oe(poe[0]), .pwm_out_b(pout[1]), .pwm_out_b_oe(poe[1]),
		.pwm_out_c(pout[2]), .pwm_out_c_oe(poe[2]), .pwm_out_d(pout[3]),
		.pwm_out_d_oe(poe[3]), .steer_owned(steer_owned),
		.shutdown_status(shutdown_status), .irq(irq));
	switch_model switch_model_i (.aclk(aclk), .cmp_high(cmp_high),
		.fault_low(fault_low), .pin_out(pout), .pin_oe(poe),
		.comparator_out(comparator_out), .fault_input_pin(fault_input_pin),
		.pin_level(pin_level));
	task automatic finish_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic ta, tw, tb, pa, pw, pb;
		pa = 1; pw = 1; pb = 1;
		@(posedge aclk);
		awaddr <= a; wdata <= {24'h0, v}; wstrb <= 4'hF;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (pa || pw || pb) begin
			@(negedge aclk);
			ta = pa && awready; tw = pw && wready; tb = bvalid;
			if (tb) bres = bresp;
			@(posedge aclk);
			if (ta) begin pa = 0; awvalid <= 1'b0; end
			if (tw) begin pw = 0; wvalid <= 1'b0; end
			if (tb) begin pb = 0; bready <= 1'b0; end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v,
		output logic [1:0] rs);
		logic pa;
		pa = 1;
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (1) begin
			@(negedge aclk);
			if (pa && arready) pa = 0;
			v = rdata[7:0]; rs = rresp;
			if (rvalid) break;
			@(posedge aclk);
			if (!pa) arvalid <= 1'b0;
		end
		@(posedge aclk);
		arvalid <= 1'b0; rready <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		logic [1:0] rs;
		rd(a, v, rs);
		chk(v, exp);
		chk({6'h0, rs}, {6'h0, eccp_pkg::RESP_OKAY});
	endtask
	task automatic pulse(input logic [2:0] m);
		@(posedge aclk); tmr_period_match <= m;
		@(posedge aclk); tmr_period_match <= 3'h0;
		#1;
	endtask
	task automatic cause(input logic [2:0] v);
		@(posedge aclk); {fault_low, cmp_high} <= v;
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(eccp_pkg::TIMEBASE_OFFS, 8'h00);
		rd_chk(eccp_pkg::SHUTDOWN_OFFS, 8'h00);
		rd_chk(eccp_pkg::RESTART_OFFS, 8'h00);
		rd_chk(eccp_pkg::STEER_OFFS, 8'h01);
		rd_chk(eccp_pkg::IRQ_MASK_OFFS, 8'h00);
		rd(8'h18, d, r);
		chk({6'h0, r}, {6'h0, eccp_pkg::RESP_SLVERR});
		chk(d, 8'h00);
		wr(8'h18, 8'h55);
		chk({6'h0, bres}, {6'h0, eccp_pkg::RESP_SLVERR});
		wr(eccp_pkg::STEER_OFFS, 8'hFF);
		chk({6'h0, bres}, {6'h0, eccp_pkg::RESP_OKAY});
		rd_chk(eccp_pkg::STEER_OFFS, 8'h1F);
		wr(eccp_pkg::TIMEBASE_OFFS, 8'hE4);
		rd_chk(eccp_pkg::TIMEBASE_OFFS, 8'hE4);
		for (int i = 0; i < 3; i++) begin
			pulse(3'h1 << i);
			chk({4'h0, chan_period_match}, 8'h01 << i);
		end
		wr(eccp_pkg::STEER_OFFS, 8'h0F);
		@(posedge aclk); pwm_raw <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			@(posedge aclk); unit_mode_field <= 4'hC | m[3:0];
			waitc(8);
			chk({4'h0, steer_owned}, 8'h0F);
			chk(pins, {4'hF, ~m[0], ~m[1], ~m[0], ~m[1]});
		end
		@(posedge aclk); unit_mode_field <= 4'h8;
		waitc(8);
		chk({4'h0, steer_owned}, 8'h00);
		@(posedge aclk); unit_mode_field <= 4'hC; output_config_field <= 2'h1;
		waitc(8);
		chk({steer_owned, poe}, 8'h00);
		@(posedge aclk); output_config_field <= 2'h0; pwm_raw <= 1'b0;
		wr(eccp_pkg::STEER_OFFS, 8'h01);
		wr(eccp_pkg::RESTART_OFFS, 8'h03);
		rd_chk(eccp_pkg::RESTART_OFFS, 8'h03);
		waitc(8);
		chk(pins, 8'h10);
		@(posedge aclk); pwm_raw <= 1'b1;
		waitc(10);
		chk(pins, 8'h10);
		waitc(6);
		chk(pins, 8'h11);
		@(posedge aclk); pwm_raw <= 1'b0;
		waitc(3);
		chk(pins, 8'h10);
		wr(eccp_pkg::RESTART_OFFS, 8'h01);
		@(posedge aclk); pwm_raw <= 1'b1;
		waitc(5);
		chk(pins, 8'h10);
		waitc(1);
		chk(pins, 8'h11);
		@(posedge aclk); pwm_raw <= 1'b0;
		waitc(3);
		chk(pins, 8'h10);
		wr(eccp_pkg::RESTART_OFFS, 8'h00);
		wr(eccp_pkg::STEER_OFFS, 8'h1F);
		waitc(8);
		chk({4'h0, steer_owned}, 8'h01);
		pulse(3'h1);
		waitc(2);
		chk({4'h0, steer_owned}, 8'h0F);
		wr(eccp_pkg::STEER_OFFS, 8'h0F);
		for (int c = 0; c < 8; c++) begin
			for (int k = 0; k < 3; k++) begin
				wr(eccp_pkg::SHUTDOWN_OFFS, {1'b0, c[2:0], 4'h5});
				cause(3'h1 << k);
				waitc(8);
				chk({7'h0, shutdown_status}, {7'h0, |(c[2:0] & (3'h1 << k))});
				cause(3'h0);
				waitc(8);
				wr(eccp_pkg::SHUTDOWN_OFFS, {1'b0, c[2:0], 4'h5});
			end
		end
		pulse(3'h1);
		waitc(3);
		wr(eccp_pkg::IRQ_MASK_OFFS, 8'h03);
		wr(eccp_pkg::IRQ_STATUS_OFFS, 8'h03);
		chk({7'h0, irq}, 8'h00);
		wr(eccp_pkg::SHUTDOWN_OFFS, 8'h14);
		cause(3'h1);
		waitc(8);
		chk({irq, 6'h0, shutdown_status}, 8'h81);
		chk(pins, 8'hF5);
		cause(3'h0);
		waitc(8);
		chk({7'h0, shutdown_status}, 8'h01);
		wr(eccp_pkg::SHUTDOWN_OFFS, 8'h14);
		waitc(4);
		chk({7'h0, shutdown_status}, 8'h00);
		chk(pins, 8'hF5);
		pulse(3'h1);
		waitc(3);
		chk(pins, 8'hF0);
		rd_chk(eccp_pkg::IRQ_STATUS_OFFS, 8'h03);
		wr(eccp_pkg::IRQ_STATUS_OFFS, 8'h01);
		rd_chk(eccp_pkg::IRQ_STATUS_OFFS, 8'h02);
		chk({7'h0, irq}, 8'h01);
		wr(eccp_pkg::IRQ_MASK_OFFS, 8'h01);
		chk({7'h0, irq}, 8'h00);
		wr(eccp_pkg::SHUTDOWN_OFFS, 8'h1A);
		cause(3'h1);
		waitc(8);
		chk(pins, 8'h00);
		wr(eccp_pkg::RESTART_OFFS, 8'h80);
		cause(3'h0);
		waitc(8);
		chk({7'h0, shutdown_status}, 8'h00);
		pulse(3'h1);
		waitc(3);
		chk(pins, 8'hF0);
		@(posedge aclk); comparator_sync_option <= 2'h1;
		cause(3'h1);
		waitc(10);
		chk({7'h0, shutdown_status}, 8'h00);
		@(posedge aclk); timer1_sync_tick <= 1'b1;
		@(posedge aclk); timer1_sync_tick <= 1'b0;
		waitc(4);
		chk({7'h0, shutdown_status}, 8'h01);
		rd_chk(eccp_pkg::SHUTDOWN_OFFS, 8'h9A);
		wr(eccp_pkg::TIMEBASE_OFFS, 8'hE1);
		pulse(3'h2);
		chk({4'h0, chan_period_match}, 8'h01);
		finish_test();
	end
endmodule
